// >>> src/pok_pkg.sv
// Shared constants and carrier types for the power-ok and top event flag block.
// Assumes a byte-wide register port driven by a serial interface decoder on clk.
package pok_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_OPTIONS = 8'h16;
  localparam logic [7:0] ADDR_FAULT = 8'h17;
  localparam logic [7:0] ADDR_SRESET = 8'h18;
  localparam logic [7:0] ADDR_TOP = 8'h19;
  // Options field positions and reset value
  localparam int OPT_MODE = 0;
  localparam int OPT_FAULT_GATES = 1;
  localparam int OPT_TWARN_GATES = 2;
  localparam logic [7:0] OPTIONS_RST = 8'h01;
  localparam logic [7:0] OPTIONS_MASK = 8'h07;
  // Top event flag positions
  localparam int TOP_PWR_DROP = 7;
  localparam int TOP_LIN_SUM = 6;
  localparam int TOP_CONV_SUM = 5;
  localparam int TOP_EXT_CLK = 4;
  localparam int TOP_THERM_SD = 3;
  localparam int TOP_THERM_WARN = 2;
  localparam int TOP_OVERVOLT = 1;
  localparam int TOP_LOAD_RDY = 0;
  localparam logic [7:0] TOP_W1C_MASK = 8'h9F;
  localparam int SRESET_BIT = 0;
  // Number of monitored outputs: converter0, converter1, linear0, linear1
  localparam int N_OUT = 4;
  // Cycles the software reset pulse stands
  localparam int SRESET_CYCLES = 1;

  // Register write/read request from the serial decoder
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // Live event inputs from the analog and neighbouring digital blocks
  typedef struct packed {
    logic [N_OUT-1:0] out_valid;
    logic ext_clk_change;
    logic therm_sd;
    logic therm_warn;
    logic overvolt;
    logic load_ready;
    logic [7:0] conv_events;
    logic [7:0] lin_events;
  } event_in_t;

  // Power-ok configuration owned by the neighbouring options register
  typedef struct packed {
    logic polarity;
    logic [N_OUT-1:0] src_enable;
  } pok_cfg_t;

  typedef enum logic [0:0] {
    SR_IDLE = 1'b0,
    SR_PULSE = 1'b1
  } sreset_state_t;
endpackage

// >>> src/power_ok_flags.sv
// Power-ok output forming, fault source latches, software reset and top event flags.
// Assumes the register request comes from a serial decoder on clk; event inputs
// are asynchronous to clk and are synchronised here.
// Notes on behaviour
// RULE_01: With warning gating set, an active thermal warning forces power-ok inactive.
// RULE_02: Fault-gating zero follows live outputs; one follows latched faults.
// RULE_03: Mode bit: zero gated, one continuous; resets to one.
// RULE_04: Each selected output that drops power-ok sets its own fault latch.
// RULE_05: Writing one clears a fault latch only while that output is valid.
// RULE_06: Software reset returns registers to defaults, reloads memory, resets interface.
// RULE_07: The software reset bit clears itself with no further write.
// RULE_08: Power-ok active-to-inactive transition latches flag bit 7.
// RULE_09: Bit 6 reads set while linear regulator events are pending.
// RULE_10: Bit 5 reads set while converter events are pending.
// RULE_11: External clock appearing or vanishing latches bit 4.
// RULE_12: Thermal shutdown latches bit 3, disables regulators, drives outputs low.
// RULE_13: While bit 3 stays set, no regulator may be enabled.
// RULE_14: Thermal warning latches bit 2; live status reported separately.
// RULE_15: Input overvoltage latches bit 1, disables regulators, drives outputs low.
// RULE_16: New load current result latches bit 0.
// RULE_17: Host clears latched top flags by writing one; only those bits clear.
// RULE_18: Polarity zero drives power-ok high when valid; one drives low.
// RULE_19: Only outputs with their source enable set affect power-ok.
// RULE_20: Power-ok valid only when all enabled sources valid; zero writes ignored.
module power_ok_flags
  import pok_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire reg_req_t req,
  output logic [7:0] rdata,
  input wire event_in_t ev_async,
  input wire pok_cfg_t cfg,
  input wire logic [1:0] reg_enable_req,
  output logic [1:0] reg_enable,
  output logic power_ok_output,
  output logic general_output_force_low,
  output logic software_reset_trigger,
  output logic [2:0] thermal_live_status
);

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers; the first stage feeds only the second
  localparam int EV_W = $bits(event_in_t);
  logic [EV_W-1:0] ev_meta_r;
  logic [EV_W-1:0] ev_sync_r;
  event_in_t ev;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_meta_r <= '0;
      ev_sync_r <= '0;
    end else begin
      ev_meta_r <= ev_async;
      ev_sync_r <= ev_meta_r;
    end
  end
  assign ev = event_in_t'(ev_sync_r);

  // Previous synchronised levels for edge detection
  logic ext_clk_d_r;
  logic therm_sd_d_r;
  logic therm_warn_d_r;
  logic overvolt_d_r;
  logic load_ready_d_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_clk_d_r <= 1'b0;
      therm_sd_d_r <= 1'b0;
      therm_warn_d_r <= 1'b0;
      overvolt_d_r <= 1'b0;
      load_ready_d_r <= 1'b0;
    end else begin
      ext_clk_d_r <= ev.ext_clk_change;
      therm_sd_d_r <= ev.therm_sd;
      therm_warn_d_r <= ev.therm_warn;
      overvolt_d_r <= ev.overvolt;
      load_ready_d_r <= ev.load_ready;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sync fill tracker: for a few cycles after reset the stages and the edge
  // detectors hold zeros, which would read as invalid outputs and a clock toggle
  logic [2:0] fill_r;
  logic primed;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fill_r <= 3'b000;
    end else begin
      fill_r <= {fill_r[1:0], 1'b1};
    end
  end
  assign primed = fill_r[2]; // Sync stages and edge history both hold live values

  //////////////////////////////////////////////////////////////////////////////
  // Register write decode
  function automatic logic wr_hit(input reg_req_t r, input logic [7:0] a);
    wr_hit = r.wr && (r.addr == a);
  endfunction

  logic sreset_hit;
  logic soft_rst;
  sreset_state_t sr_state_r;
  sreset_state_t sr_state_nxt;

  assign sreset_hit = wr_hit(req, ADDR_SRESET) && req.wdata[SRESET_BIT];
  assign soft_rst = (sr_state_r == SR_PULSE);

  //////////////////////////////////////////////////////////////////////////////
  // Software reset: one-cycle pulse, then the bit clears itself
  always_comb begin
    case (sr_state_r)
      SR_IDLE: sr_state_nxt = sreset_hit ? SR_PULSE : SR_IDLE;
      SR_PULSE: sr_state_nxt = SR_IDLE; // RULE_07
      default: sr_state_nxt = SR_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sr_state_r <= SR_IDLE;
      software_reset_trigger <= 1'b0;
    end else begin
      sr_state_r <= sr_state_nxt;
      software_reset_trigger <= (sr_state_nxt == SR_PULSE); // RULE_06
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Options register; soft reset returns it to default
  logic [7:0] options_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      options_r <= OPTIONS_RST; // RULE_03
    end else if (soft_rst) begin
      options_r <= OPTIONS_RST; // RULE_06
    end else if (wr_hit(req, ADDR_OPTIONS)) begin
      options_r <= req.wdata & OPTIONS_MASK;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Power-ok forming
  logic [N_OUT-1:0] src_bad;
  logic live_ok;
  logic fault_ok;
  logic pok_valid;
  logic pok_valid_d_r;
  logic [3:0] fault_r;

  assign src_bad = cfg.src_enable & ~ev.out_valid; // RULE_19
  assign live_ok = (src_bad == '0); // RULE_20
  assign fault_ok = (fault_r == '0);
  // Gated mode holds power-ok off during shutdown or overvoltage; continuous
  // mode leaves those to the per-output monitors.
  always_comb begin
    pok_valid = options_r[OPT_FAULT_GATES] ? fault_ok : live_ok; // RULE_02
    if (options_r[OPT_TWARN_GATES] && ev.therm_warn) begin
      pok_valid = 1'b0; // RULE_01
    end
    if (!options_r[OPT_MODE] && (ev.therm_sd || ev.overvolt)) begin
      pok_valid = 1'b0; // RULE_03
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_ok_output <= 1'b0;
      pok_valid_d_r <= 1'b0;
    end else begin
      power_ok_output <= pok_valid ^ cfg.polarity; // RULE_18
      pok_valid_d_r <= pok_valid;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Fault source latches; set wins over a same-cycle clear
  logic [N_OUT-1:0] fault_set;
  logic [N_OUT-1:0] fault_clr;

  assign fault_set = src_bad & {N_OUT{primed}}; // RULE_04
  assign fault_clr = {N_OUT{wr_hit(req, ADDR_FAULT)}} & req.wdata[N_OUT-1:0] & ev.out_valid; // RULE_05

  generate
    for (genvar i = 0; i < N_OUT; i++) begin : g_fault
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          fault_r[i] <= 1'b0;
        end else if (fault_set[i]) begin
          fault_r[i] <= 1'b1; // RULE_04
        end else if (soft_rst || fault_clr[i]) begin
          fault_r[i] <= 1'b0; // RULE_05
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Top event flags; hardware set wins over a same-cycle write-one clear
  logic [7:0] top_r;
  logic [7:0] top_set;
  logic [7:0] top_clr;

  always_comb begin
    top_set = 8'h00;
    top_set[TOP_PWR_DROP] = pok_valid_d_r && !pok_valid; // RULE_08
    top_set[TOP_EXT_CLK] = primed && (ev.ext_clk_change ^ ext_clk_d_r); // RULE_11
    top_set[TOP_THERM_SD] = ev.therm_sd && !therm_sd_d_r; // RULE_12
    top_set[TOP_THERM_WARN] = ev.therm_warn && !therm_warn_d_r; // RULE_14
    top_set[TOP_OVERVOLT] = ev.overvolt && !overvolt_d_r; // RULE_15
    top_set[TOP_LOAD_RDY] = ev.load_ready && !load_ready_d_r; // RULE_16
  end

  // Writes of zero leave bits alone
  assign top_clr = wr_hit(req, ADDR_TOP) ? (req.wdata & TOP_W1C_MASK) : 8'h00; // RULE_17

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      top_r <= 8'h00;
    end else if (soft_rst) begin
      top_r <= top_set;
    end else begin
      top_r <= (top_set | (top_r & ~top_clr)) & TOP_W1C_MASK; // RULE_17
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Protection: disable regulators and force general outputs low
  logic protect;
  assign protect = top_r[TOP_THERM_SD] || ev.therm_sd || ev.overvolt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_enable <= 2'b00;
      general_output_force_low <= 1'b0;
      thermal_live_status <= 3'b000;
    end else begin
      reg_enable <= protect ? 2'b00 : reg_enable_req; // RULE_13
      general_output_force_low <= ev.therm_sd || ev.overvolt; // RULE_15
      thermal_live_status <= {ev.therm_sd, ev.therm_warn, ev.overvolt}; // RULE_14
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read mux; summaries are computed live from the event registers
  logic [7:0] top_view;
  always_comb begin
    top_view = top_r;
    top_view[TOP_LIN_SUM] = (ev.lin_events != 8'h00); // RULE_09
    top_view[TOP_CONV_SUM] = (ev.conv_events != 8'h00); // RULE_10
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        ADDR_OPTIONS: rdata <= options_r;
        ADDR_FAULT: rdata <= {4'h0, fault_r};
        ADDR_SRESET: rdata <= {7'h00, soft_rst}; // RULE_07
        ADDR_TOP: rdata <= top_view;
        default: rdata <= 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  // Output forming
  a_twarn_gate: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
    (options_r[OPT_TWARN_GATES] && ev.therm_warn) |=> (power_ok_output == $past(cfg.polarity)))
    else $error("power ok not forced inactive on warning");
  a_twarn_off: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
    (!options_r[OPT_TWARN_GATES] && options_r[OPT_MODE] && !options_r[OPT_FAULT_GATES] && live_ok)
    |=> (power_ok_output != $past(cfg.polarity)))
    else $error("power ok dropped although warning gating is off");
  a_fault_gate: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
    (options_r[OPT_FAULT_GATES] && fault_r != '0) |=> (power_ok_output == $past(cfg.polarity)))
    else $error("fault latch did not gate power ok");
  a_live_follow: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
    (!options_r[OPT_FAULT_GATES] && src_bad != '0) |=> (power_ok_output == $past(cfg.polarity)))
    else $error("power ok ignored an invalid live source");
  a_mode_gated: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
    (!options_r[OPT_MODE] && (ev.therm_sd || ev.overvolt)) |=> (power_ok_output == $past(cfg.polarity)))
    else $error("gated mode did not hold power ok inactive");
  a_valid_level: assert property (@(posedge clk) disable iff (!rst_n) // RULE_18
    pok_valid |=> (power_ok_output != $past(cfg.polarity)))
    else $error("power ok level wrong for polarity");
  // Fault latches
  a_fault_set: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
    (primed && src_bad[0]) |=> fault_r[0])
    else $error("fault latch not set");
  a_fault_keep: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
    (fault_r[0] && !ev.out_valid[0] && !soft_rst) |=> fault_r[0])
    else $error("fault latch cleared while output invalid");
  a_fault_clear: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
    (fault_r[0] && wr_hit(req, ADDR_FAULT) && req.wdata[0] && ev.out_valid[0] && !fault_set[0]) |=> !fault_r[0])
    else $error("fault latch kept after valid clear");
  // Software reset
  a_sreset_self: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
    soft_rst |=> !soft_rst)
    else $error("software reset did not self clear");
  a_sreset_defaults: assert property (@(posedge clk) disable iff (!rst_n) // RULE_06
    soft_rst |=> (options_r == OPTIONS_RST))
    else $error("options not restored by software reset");
  a_trigger_once: assert property (@(posedge clk) disable iff (!rst_n) // RULE_06
    software_reset_trigger |=> !software_reset_trigger)
    else $error("reset trigger longer than one cycle");
  // Event flags and protection
  a_drop_flag: assert property (@(posedge clk) disable iff (!rst_n) // RULE_08
    (pok_valid_d_r && !pok_valid) |=> top_r[TOP_PWR_DROP])
    else $error("power drop flag missed");
  a_extclk_latch: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
    (primed && (ev.ext_clk_change != ext_clk_d_r)) |=> top_r[TOP_EXT_CLK])
    else $error("external clock flag missed");
  a_sd_latch: assert property (@(posedge clk) disable iff (!rst_n) // RULE_12
    (ev.therm_sd && !therm_sd_d_r) |=> top_r[TOP_THERM_SD])
    else $error("shutdown flag missed");
  a_warn_latch: assert property (@(posedge clk) disable iff (!rst_n) // RULE_14
    (ev.therm_warn && !therm_warn_d_r) |=> top_r[TOP_THERM_WARN])
    else $error("warning flag missed");
  a_ov_outputs: assert property (@(posedge clk) disable iff (!rst_n) // RULE_15
    ev.overvolt |=> (general_output_force_low && reg_enable == 2'b00))
    else $error("overvoltage did not disable outputs");
  a_load_latch: assert property (@(posedge clk) disable iff (!rst_n) // RULE_16
    (ev.load_ready && !load_ready_d_r) |=> top_r[TOP_LOAD_RDY])
    else $error("load result flag missed");
  a_sd_block: assert property (@(posedge clk) disable iff (!rst_n) // RULE_13
    top_r[TOP_THERM_SD] |=> (reg_enable == 2'b00))
    else $error("regulator enabled during shutdown flag");
  a_w1c_keep: assert property (@(posedge clk) disable iff (!rst_n) // RULE_17
    (top_r[TOP_LOAD_RDY] && !soft_rst && !(wr_hit(req, ADDR_TOP) && req.wdata[TOP_LOAD_RDY]))
    |=> top_r[TOP_LOAD_RDY])
    else $error("flag cleared without write of one");
  a_sum_lin: assert property (@(posedge clk) disable iff (!rst_n) // RULE_09
    (req.rd && req.addr == ADDR_TOP) |=> (rdata[TOP_LIN_SUM] == ($past(ev.lin_events) != 8'h00)))
    else $error("linear summary bit wrong");
  a_sum_conv: assert property (@(posedge clk) disable iff (!rst_n) // RULE_10
    (req.rd && req.addr == ADDR_TOP) |=> (rdata[TOP_CONV_SUM] == ($past(ev.conv_events) != 8'h00)))
    else $error("converter summary bit wrong");

  // Main scenarios
  c_sreset: cover property (@(posedge clk) disable iff (!rst_n) soft_rst);
  c_warn_gate: cover property (@(posedge clk) disable iff (!rst_n) options_r[OPT_TWARN_GATES] && ev.therm_warn);
  c_drop: cover property (@(posedge clk) disable iff (!rst_n) $rose(top_r[TOP_PWR_DROP]));
  c_fault_clear: cover property (@(posedge clk) disable iff (!rst_n) $fell(fault_r[0]));
  c_sd: cover property (@(posedge clk) disable iff (!rst_n) $rose(top_r[TOP_THERM_SD]));
endmodule

// >>> tb/pok_host.sv
// Host model: issues byte register cycles on the request port.
// Assumes the bench calls cyc and that inputs change on falling edges.
module pok_host
  import pok_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] rdata,
  output reg_req_t req
);
  timeunit 1ns;
  timeprecision 1ps;

  initial req = '0;

  // Request holds through its taking edge; on release the address and
  // data lines show the inverse so a stale value never passes for live
  task automatic cyc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    @(negedge clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    q = rdata;
  endtask
endmodule

// >>> tb/power_ok_flags_tb.sv
// Self-checking bench for the power-ok and top event flag block.
// Assumes one 40 MHz clock; all inputs move on falling edges.
module power_ok_flags_tb
  import pok_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [7:0] stim;
    logic [7:0] top;
    logic gfl;
    logic [1:0] en;
  } row_t;

  logic clk = 1'b0;
  logic rst_n;
  reg_req_t req;
  logic [7:0] rdata;
  event_in_t ev;
  pok_cfg_t cfg;
  logic [1:0] reg_enable_req;
  logic [1:0] reg_enable;
  logic power_ok_output;
  logic general_output_force_low;
  logic software_reset_trigger;
  logic [2:0] thermal_live_status;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  int pulses = 0;
  logic [7:0] q;
  row_t rows [7] = '{
    '{8'h01, 8'h01, 1'b0, 2'b11}, '{8'h02, 8'h02, 1'b1, 2'b00}, '{8'h04, 8'h04, 1'b0, 2'b11},
    '{8'h08, 8'h08, 1'b1, 2'b00}, '{8'h10, 8'h10, 1'b0, 2'b11}, '{8'h20, 8'h20, 1'b0, 2'b11},
    '{8'h40, 8'h40, 1'b0, 2'b11}};

  always #12.5 clk = ~clk;

  pok_host pok_host_i (.clk(clk), .rdata(rdata), .req(req));

  power_ok_flags power_ok_flags_i (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .ev_async(ev),
    .cfg(cfg), .reg_enable_req(reg_enable_req), .reg_enable(reg_enable), .power_ok_output(power_ok_output),
    .general_output_force_low(general_output_force_low), .software_reset_trigger(software_reset_trigger),
    .thermal_live_status(thermal_live_status));

  ////////////////////////////////////////////////////////////////////////////
  // Pulse counter and hang guard; a stuck handshake would otherwise run forever
  always @(negedge clk) begin
    if (software_reset_trigger === 1'b1) pulses++;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared checks and bus helpers
  task automatic check(input string n, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    pok_host_i.cyc(1'b1, a, d, q);
  endtask

  task automatic rdck(input string n, input logic [7:0] a, input logic [7:0] exp);
    pok_host_i.cyc(1'b0, a, 8'h00, q);
    check(n, exp, q);
  endtask

  // Event levels pass two sync flops, so four cycles cover the latency
  task automatic apply(input logic [7:0] s);
    @(negedge clk);
    ev.load_ready = s[0];
    ev.overvolt = s[1];
    ev.therm_warn = s[2];
    ev.therm_sd = s[3];
    ev.ext_clk_change = s[4];
    ev.conv_events = s[5] ? 8'h44 : 8'h00;
    ev.lin_events = s[6] ? 8'h06 : 8'h00;
    repeat (4) @(negedge clk);
  endtask

  task automatic pok(input string n, input logic e);
    check(n, {7'h0, e}, {7'h0, power_ok_output});
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, table of events, then hand-written cases
  initial begin
    rst_n = 1'b0;
    ev = '0;
    ev.out_valid = 4'hF;
    cfg = '0;
    reg_enable_req = 2'b11;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    rdck("options", ADDR_OPTIONS, OPTIONS_RST);
    rdck("faults", ADDR_FAULT, 8'h00);
    rdck("unmapped", 8'h20, 8'h00);
    pok("pok_rst", 1'b1);
    foreach (rows[i]) begin
      apply(rows[i].stim);
      rdck("top", ADDR_TOP, rows[i].top);
      check("force_low", {7'h0, rows[i].gfl}, {7'h0, general_output_force_low});
      check("enable", {6'h0, rows[i].en}, {6'h0, reg_enable});
      check("live_stat", {5'h0, rows[i].stim[3:1]}, {5'h0, thermal_live_status});
      apply(8'h00);
      check("en_held", {6'h0, rows[i].stim[3] ? 2'b00 : 2'b11}, {6'h0, reg_enable});
      wr(ADDR_TOP, 8'hFF);
      rdck("top_clr", ADDR_TOP, 8'h00);
      check("en_back", 8'h03, {6'h0, reg_enable});
    end
    // Only the bits written with one may clear
    apply(8'h05);
    apply(8'h00);
    wr(ADDR_TOP, 8'h01);
    wr(ADDR_TOP, 8'h00);
    rdck("partial", ADDR_TOP, 8'h04);
    wr(ADDR_TOP, 8'h04);
    // Selected source drops, latch refuses clear while invalid
    cfg.src_enable = 4'b0001;
    ev.out_valid = 4'b1110;
    repeat (4) @(negedge clk);
    pok("pok_drop", 1'b0);
    wr(ADDR_FAULT, 8'h01);
    rdck("fault_set", ADDR_FAULT, 8'h01);
    rdck("drop_flag", ADDR_TOP, 8'h80);
    // Source deselected but still invalid: the clear must be refused on its own
    cfg.src_enable = 4'b0000;
    wr(ADDR_FAULT, 8'h01);
    rdck("fault_kept", ADDR_FAULT, 8'h01);
    cfg.src_enable = 4'b0001;
    ev.out_valid = 4'hF;
    repeat (4) @(negedge clk);
    pok("pok_live", 1'b1);
    wr(ADDR_OPTIONS, 8'h03);
    repeat (2) @(negedge clk);
    pok("pok_latched", 1'b0);
    wr(ADDR_FAULT, 8'h01);
    rdck("fault_clr", ADDR_FAULT, 8'h00);
    pok("pok_relatch", 1'b1);
    ev.out_valid = 4'b1101;
    repeat (4) @(negedge clk);
    pok("pok_ignored", 1'b1);
    ev.out_valid = 4'hF;
    cfg.polarity = 1'b1;
    repeat (3) @(negedge clk);
    pok("pok_polarity", 1'b0);
    cfg.polarity = 1'b0;
    // Warning gating on and off
    wr(ADDR_OPTIONS, 8'h05);
    ev.therm_warn = 1'b1;
    repeat (4) @(negedge clk);
    pok("pok_warn", 1'b0);
    wr(ADDR_OPTIONS, 8'h01);
    repeat (2) @(negedge clk);
    pok("pok_nowarn", 1'b1);
    ev.therm_warn = 1'b0;
    // Gated mode lets a live overvoltage pull power-ok inactive
    wr(ADDR_OPTIONS, 8'h00);
    ev.overvolt = 1'b1;
    repeat (4) @(negedge clk);
    pok("pok_gated", 1'b0);
    ev.overvolt = 1'b0;
    repeat (4) @(negedge clk);
    // Enable requests pass through unchanged when nothing protects
    reg_enable_req = 2'b01;
    repeat (3) @(negedge clk);
    check("en_pass", 8'h01, {6'h0, reg_enable});
    // Software reset pulses once and restores defaults
    wr(ADDR_OPTIONS, 8'h06);
    wr(ADDR_SRESET, 8'h01);
    repeat (3) @(negedge clk);
    check("pulses", 8'h01, pulses[7:0]);
    rdck("opt_dflt", ADDR_OPTIONS, OPTIONS_RST);
    rdck("sreset_bit", ADDR_SRESET, 8'h00);
    rdck("top_dflt", ADDR_TOP, 8'h00);
    close_out();
  end
endmodule
